// ===== srs_route.sv
/*
 * Package for the sequence running status block, plus the output router
 * that places the flag onto one of the four system outputs.
 * Assumes a single clock pclk and an asynchronous active-low presetn.
 */
`timescale 1ns/1ps

package srs_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF    = 8'h00;
   localparam logic [7:0] STATUS_OFF  = 8'h04;
   // Control and status field positions
   localparam int         MODE_LSB    = 0;
   localparam int         SEL_LSB     = 2;
   localparam int         EN_BIT      = 4;
   localparam int         POL_BIT     = 5;
   localparam int         FLAG_BIT    = 0;
   // Reset values
   localparam logic [1:0] MODE_RST    = 2'h0;
   localparam logic [1:0] SEL_RST     = 2'h0;
   localparam logic       EN_RST      = 1'b0;
   localparam logic       POL_RST     = 1'b1;
   // Mode in which the flag reaches the outputs and the host
   localparam logic [1:0] MODE_ROUTE  = 2'h0;
   localparam int         NUM_OUTS    = 4;
   // Cycles from request to APB answer
   localparam int         APB_WAITS   = 1;

   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] run_output_select;
      logic       run_output_enable;
      logic       run_output_polarity;
   } srs_cfg_s;

   typedef struct packed {
      logic [NUM_OUTS-1:0] val;
      logic [NUM_OUTS-1:0] own;
   } srs_route_s;
endpackage : srs_pkg

module srs_route (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // Flag and settings
   input  wire logic              sequence_running_flag,
   input  wire srs_pkg::srs_cfg_s cfg,
   // System output drive
   output srs_pkg::srs_route_s    route
);

   logic                         routed;
   logic [srs_pkg::NUM_OUTS-1:0] next_own;
   logic [srs_pkg::NUM_OUTS-1:0] next_val;

   assign routed = (cfg.mode == srs_pkg::MODE_ROUTE) && cfg.run_output_enable;

   genvar i;
   generate
      for (i = 0; i < srs_pkg::NUM_OUTS; i++)
      begin : g_out
         assign next_own[i] = routed && (cfg.run_output_select == 2'(i));
         // Active level from polarity; unowned outputs left at zero
         assign next_val[i] = next_own[i] &&
                              (sequence_running_flag ~^ cfg.run_output_polarity);
      end
   endgenerate

   // One register for the whole output drive
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         route.own <= '0;
         route.val <= '0;
      end
      else
      begin
         route.own <= next_own;
         route.val <= next_val;
      end
   end

endmodule : srs_route

// ===== srs_top.sv
/*
 * Sequence running status block: keeps the flag that says a stored
 * sequence is executing, answers APB and sequence-side reads of it and
 * routes it onto a system output in mode 0.
 * Assumes seq_engine_busy comes from the sequence engine on pclk.
 */
// Decided for this implementation: the address map and the APB interface to the registers.
// Notes on behaviour
// - Flag is 1 while any sequence executes
// - Flag follows engine state every cycle
// - Each host query in mode 0 returns current flag value
// - Mode 0 routes flag to selected output
// - Modes 1-3 hide flag from outputs and host
// - Routed output uses polarity setting
// - Immediate read only mode 0; sequence any

`timescale 1ns/1ps

module srs_top (
   // Clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic [31:0]              prdata,
   output logic                     pslverr,
   // Sequence engine
   input  wire logic                seq_engine_busy,
   input  wire logic                seq_query,
   output logic                     seq_query_valid,
   output logic                     seq_query_data,
   // System outputs
   output logic [3:0]               sys_out_val,
   output logic [3:0]               sys_out_own
);

   srs_pkg::srs_cfg_s   cfg;
   srs_pkg::srs_route_s route;
   logic                sequence_running_flag;
   logic                access;
   logic                done;
   logic                hit_ctrl;
   logic                hit_stat;
   logic                flag_open;
   logic [31:0]         next_rdata;
   logic                next_err;

   assign access    = psel && penable;
   assign done      = access && pready;
   assign hit_ctrl  = (paddr == srs_pkg::CTRL_OFF);
   assign hit_stat  = (paddr == srs_pkg::STATUS_OFF);
   assign flag_open = (cfg.mode == srs_pkg::MODE_ROUTE);

   // Flag tracks the engine
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sequence_running_flag <= 1'b0;
      else
         sequence_running_flag <= seq_engine_busy;
   end

   // Control register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg.mode                <= srs_pkg::MODE_RST;
         cfg.run_output_select   <= srs_pkg::SEL_RST;
         cfg.run_output_enable   <= srs_pkg::EN_RST;
         cfg.run_output_polarity <= srs_pkg::POL_RST;
      end
      else if (done && pwrite && hit_ctrl)
      begin
         cfg.mode                <= pwdata[srs_pkg::MODE_LSB +: 2];
         cfg.run_output_select   <= pwdata[srs_pkg::SEL_LSB +: 2];
         cfg.run_output_enable   <= pwdata[srs_pkg::EN_BIT];
         cfg.run_output_polarity <= pwdata[srs_pkg::POL_BIT];
      end
   end

   // Read data and error decode
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      if (hit_ctrl)
      begin
         next_rdata[srs_pkg::MODE_LSB +: 2] = cfg.mode;
         next_rdata[srs_pkg::SEL_LSB +: 2]  = cfg.run_output_select;
         next_rdata[srs_pkg::EN_BIT]        = cfg.run_output_enable;
         next_rdata[srs_pkg::POL_BIT]       = cfg.run_output_polarity;
      end
      else if (hit_stat)
      begin
         // Immediate read refused outside mode 0
         if (pwrite || !flag_open)
            next_err = 1'b1;
         else
            next_rdata[srs_pkg::FLAG_BIT] = sequence_running_flag;
      end
      else
         next_err = 1'b1;
   end

   // APB answer after one wait cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= access && !pready;
         prdata  <= (access && !pready && !pwrite) ? next_rdata : 32'h0000_0000;
         pslverr <= access && !pready && next_err;
      end
   end

   // Sequence-side read, any mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seq_query_valid <= 1'b0;
         seq_query_data  <= 1'b0;
      end
      else
      begin
         seq_query_valid <= seq_query;
         seq_query_data  <= seq_query && sequence_running_flag;
      end
   end

   srs_route u_route (
      .pclk                  (pclk),
      .presetn               (presetn),
      .sequence_running_flag (sequence_running_flag),
      .cfg                   (cfg),
      .route                 (route)
   );

   assign sys_out_val = route.val;
   assign sys_out_own = route.own;

   // Assertions
   property p_flag_follow;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> (sequence_running_flag == $past(seq_engine_busy));
   endproperty
   a_flag_follow: assert property (p_flag_follow)
      else $error("Flag does not follow engine");

   property p_flag_hold;
      @(posedge pclk) disable iff (!presetn)
      seq_engine_busy [*3] |-> sequence_running_flag [*2];
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("Flag dropped while engine busy");

   property p_hidden;
      @(posedge pclk) disable iff (!presetn)
      (cfg.mode != srs_pkg::MODE_ROUTE) |=> (sys_out_own == 4'h0);
   endproperty
   a_hidden: assert property (p_hidden)
      else $error("Flag routed outside mode 0");

   property p_select;
      @(posedge pclk) disable iff (!presetn)
      (flag_open && cfg.run_output_enable)
         |=> (sys_out_own == (4'h1 << $past(cfg.run_output_select)));
   endproperty
   a_select: assert property (p_select)
      else $error("Wrong output selected");

   property p_level;
      @(posedge pclk) disable iff (!presetn)
      (flag_open && cfg.run_output_enable)
         |=> (sys_out_val[$past(cfg.run_output_select)]
              == ($past(sequence_running_flag) ~^ $past(cfg.run_output_polarity)));
   endproperty
   a_level: assert property (p_level)
      else $error("Routed level wrong");

   property p_untouched;
      @(posedge pclk) disable iff (!presetn)
      (sys_out_val & ~sys_out_own) == 4'h0;
   endproperty
   a_untouched: assert property (p_untouched)
      else $error("Unassigned output driven");

   property p_imm_refuse;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_stat && !flag_open)
         ##1 (psel && penable && $stable(cfg.mode)) |=> pslverr;
   endproperty
   a_imm_refuse: assert property (p_imm_refuse)
      else $error("Immediate read accepted outside mode 0");

   property p_imm_value;
      @(posedge pclk) disable iff (!presetn)
      (done && !pwrite && hit_stat && !pslverr)
         |-> (prdata[srs_pkg::FLAG_BIT] == $past(sequence_running_flag));
   endproperty
   a_imm_value: assert property (p_imm_value)
      else $error("Status read returns stale flag");

   property p_seq_query;
      @(posedge pclk) disable iff (!presetn)
      seq_query |=> (seq_query_valid && seq_query_data == $past(sequence_running_flag));
   endproperty
   a_seq_query: assert property (p_seq_query)
      else $error("Sequence query not answered");

   property p_ready_pulse;
      @(posedge pclk) disable iff (!presetn)
      access ##1 access |-> pready || $past(pready);
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("Access phase longer than one wait");

   c_run_poll: cover property (@(posedge pclk) disable iff (!presetn)
      done && hit_stat && !pslverr && prdata[0]);
   c_run_end: cover property (@(posedge pclk) disable iff (!presetn)
      $fell(sequence_running_flag) && sys_out_own != 4'h0);
   c_refused: cover property (@(posedge pclk) disable iff (!presetn)
      done && pslverr && hit_stat);
   c_seq_read: cover property (@(posedge pclk) disable iff (!presetn)
      seq_query_valid && cfg.mode != srs_pkg::MODE_ROUTE);

endmodule : srs_top

// ===== srs_host.sv
/*
 * Host model: APB master that polls and configures the status block.
 * Assumes tasks are called right after a rising edge of pclk; each call
 * returns one edge after the bus is released.
 */
`timescale 1ns/1ps

module srs_host (
   // Clock
   input  wire logic        pclk,
   // APB master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
   end

   // One transfer; waits for pready, any query answered anew
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released lines show junk
      paddr   <= ~a;
      pwdata  <= ~d;
      // Let an edge pass so a following call never reassigns in this step
      @(posedge pclk);
   endtask : xfer
endmodule : srs_host

// ===== tb.sv
/*
 * Self-checking bench for srs_top: random engine state, swept settings.
 * Assumes the host model srs_host drives the APB side.
 */
`timescale 1ns/1ps

module tb;
   logic pclk = 1'b0, presetn = 1'b0, busy = 1'b0, seq_query = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, qv, qd, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  oval, oown;
   logic [1:0]  md, sl;
   logic        en, pol;
   int          miscompares = 0, num_checks = 0, seed = 95864;

   always #50 pclk = ~pclk;

   srs_host u_srs_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

   srs_top u_srs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .seq_engine_busy(busy), .seq_query(seq_query),
      .seq_query_valid(qv), .seq_query_data(qd), .sys_out_val(oval), .sys_out_own(oown));

   // Expected {val, own} of the system outputs
   function automatic logic [7:0] exp_out(input logic [1:0] m, input logic [1:0] s,
                                          input logic e, input logic p, input logic f);
      logic [3:0] own;
      own = (m == srs_pkg::MODE_ROUTE && e) ? (4'h1 << s) : 4'h0;
      return {own & {4{f ~^ p}}, own};
   endfunction : exp_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic complete_run;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   initial
   begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      complete_run;
   end

   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      u_srs_host.xfer(1'b0, srs_pkg::CTRL_OFF, 32'h0, rd, err);
      chk(rd, {26'h0, srs_pkg::POL_RST, srs_pkg::EN_RST, srs_pkg::SEL_RST,
               srs_pkg::MODE_RST});
      for (int i = 0; i < 40; i++)
      begin
         {pol, sl, md} = i[4:0];
         // Mode 0 with the route switched off as a corner case
         en = (i != 4);
         busy <= 1'($random(seed));
         u_srs_host.xfer(1'b1, srs_pkg::CTRL_OFF, {26'h0, pol, en, sl, md}, rd, err);
         repeat (3) @(posedge pclk);
         @(negedge pclk);
         chk({oval, oown}, exp_out(md, sl, en, pol, busy));
         @(posedge pclk);
         u_srs_host.xfer(1'b0, srs_pkg::STATUS_OFF, 32'h0, rd, err);
         chk(rd, (md == srs_pkg::MODE_ROUTE) ? {31'h0, busy} : 32'h0);
         chk({31'h0, err}, {31'h0, (md != srs_pkg::MODE_ROUTE)});
         seq_query <= 1'b1;
         @(posedge pclk);
         seq_query <= 1'b0;
         @(negedge pclk);
         chk({qv, qd}, {1'b1, busy});
         @(posedge pclk);
      end
      // Refused accesses leave the settings alone
      u_srs_host.xfer(1'b1, srs_pkg::STATUS_OFF, 32'h3f, rd, err);
      chk(err, 1'b1);
      u_srs_host.xfer(1'b1, 8'h08, 32'h3f, rd, err);
      chk(err, 1'b1);
      u_srs_host.xfer(1'b0, srs_pkg::CTRL_OFF, 32'h0, rd, err);
      chk(rd, {26'h0, pol, en, sl, md});
      chk({31'h0, err}, 32'h0);
      complete_run;
   end
endmodule : tb
